// ===== rtl/qiorw_pkg.sv
// shared constants and types of the quad read and wrap host engine
package qiorw_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_CFG = 8'h08;
  localparam logic [7:0] OFS_LEN = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_DATA = 8'h14;
  // field positions
  localparam int CTRL_KIND_LSB = 0;
  localparam int CTRL_CONT_BIT = 4;
  localparam int CTRL_START_BIT = 8;
  localparam int CFG_QE_BIT = 0;
  localparam int CFG_QCM_BIT = 1;
  localparam int CFG_DSEL_LSB = 4;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_VALID_BIT = 1;
  localparam int ST_REFUSED_BIT = 2;
  localparam int ST_CONT_BIT = 3;
  // position of qpi_dummy_count_select inside the read-parameter byte
  localparam int PARAM_DSEL_LSB = 4;
  // opcodes and fixed bytes
  localparam logic [7:0] OPC_FAST = 8'heb;
  localparam logic [7:0] OPC_WORD = 8'he7;
  localparam logic [7:0] OPC_OCTAL = 8'he3;
  localparam logic [7:0] OPC_WRAPCFG = 8'h77;
  localparam logic [7:0] OPC_PARAM = 8'hc0;
  localparam logic [7:0] OPC_BURST = 8'h0c;
  localparam logic [7:0] EXIT_BYTE = 8'hff;
  localparam logic [7:0] MODE_CONT = 8'h20;
  localparam logic [7:0] MODE_NORMAL = 8'hff;
  // serial clock counts of each phase
  localparam logic [4:0] OPC_SPI_CLKS = 5'd8;
  localparam logic [4:0] OPC_QPI_CLKS = 5'd2;
  localparam logic [4:0] ADR_QUAD_CLKS = 5'd6;
  localparam logic [4:0] WRAP_DUMMY_CLKS = 5'd24;
  localparam logic [4:0] BYTE_SINGLE_CLKS = 5'd8;
  localparam logic [4:0] BYTE_QUAD_CLKS = 5'd2;
  localparam logic [4:0] DUM_FAST_CLKS = 5'd4;
  localparam logic [4:0] DUM_WORD_CLKS = 5'd2;
  localparam logic [4:0] DUM_QPI_00 = 5'd10;
  localparam logic [4:0] DUM_QPI_01 = 5'd4;
  localparam logic [4:0] DUM_QPI_10 = 5'd6;
  localparam logic [4:0] DUM_QPI_11 = 5'd8;
  // timing
  localparam int HCLK_PERIOD_NS = 100;
  localparam int SCLK_PERIOD_NS = 800;
  localparam int SCLK_HALF_CYCLES = SCLK_PERIOD_NS / (2 * HCLK_PERIOD_NS);

  typedef enum logic [2:0] {K_FAST, K_WORD, K_OCTAL, K_WRAPCFG, K_PARAM, K_BURST, K_EXIT, K_RSVD} qiorw_kind_t;
  typedef enum logic [2:0] {PH_IDLE, PH_OPC, PH_ADR, PH_MODE, PH_DUM, PH_DATA, PH_END} qiorw_phase_t;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic [3:0] io_out;
    logic [3:0] io_oe;
  } qiorw_pins_t;

  typedef struct packed {
    qiorw_phase_t ph;
    qiorw_kind_t kind;
    logic [4:0] left;
    logic [7:0] div;
    logic sclk;
    logic cs_n;
    logic [3:0] io_out;
    logic [3:0] io_oe;
    logic [31:0] sh;
    logic [3:0] rx;
    logic nib;
    logic rel;
    logic skip;
    logic [15:0] cnt;
    logic qe;
    logic qcm;
    logic [1:0] dsel;
    logic cont_req;
    logic [23:0] addr;
    logic [15:0] len;
    logic cont_active;
    qiorw_kind_t cont_kind;
    logic [7:0] data;
    logic valid;
    logic refused;
    logic start;
    logic a_sel;
    logic a_wr;
    logic [7:0] a_addr;
    logic [31:0] hrdata;
    logic [3:0] s1;
    logic [3:0] s2;
  } qiorw_state_t;
endpackage

// ===== rtl/qiorw_host.sv
// host engine for quad reads, continuous read, wrap and read-parameter commands
`timescale 1ns/10ps
module qiorw_host #(
  parameter int HALF_CYCLES = qiorw_pkg::SCLK_HALF_CYCLES
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // flash pins
  input wire logic [3:0] io_in,
  output qiorw_pkg::qiorw_pins_t flash
);

  if (HALF_CYCLES < 3 || HALF_CYCLES > 255) begin : g_bad_half
    $error("HALF_CYCLES must lie in 3..255");
  end

  localparam logic [7:0] HALF_LAST = 8'(HALF_CYCLES - 1);

  qiorw_pkg::qiorw_state_t s;
  qiorw_pkg::qiorw_state_t n;

  function automatic logic is_read(input qiorw_pkg::qiorw_kind_t k);
    return k inside {qiorw_pkg::K_FAST, qiorw_pkg::K_WORD, qiorw_pkg::K_OCTAL, qiorw_pkg::K_BURST};
  endfunction

  function automatic logic has_mode(input qiorw_pkg::qiorw_kind_t k);
    return k inside {qiorw_pkg::K_FAST, qiorw_pkg::K_WORD, qiorw_pkg::K_OCTAL};
  endfunction

  function automatic logic [4:0] qpi_dummy(input logic [1:0] ds);
    logic [4:0] r;
    r = qiorw_pkg::DUM_QPI_00;
    case (ds)
      2'b01: r = qiorw_pkg::DUM_QPI_01;
      2'b10: r = qiorw_pkg::DUM_QPI_10;
      2'b11: r = qiorw_pkg::DUM_QPI_11;
      default: r = qiorw_pkg::DUM_QPI_00;
    endcase
    return r;
  endfunction

  function automatic logic [4:0] plen(input qiorw_pkg::qiorw_kind_t k, input logic qcm, input logic [1:0] ds,
                                      input logic skip, input qiorw_pkg::qiorw_phase_t ph);
    logic [4:0] r;
    r = 5'd0;
    case (ph)
      qiorw_pkg::PH_OPC:
        if (!skip)
          r = (qcm && k != qiorw_pkg::K_EXIT) ? qiorw_pkg::OPC_QPI_CLKS : qiorw_pkg::OPC_SPI_CLKS;
      qiorw_pkg::PH_ADR:
        if (is_read(k))
          r = qiorw_pkg::ADR_QUAD_CLKS;
        else if (k == qiorw_pkg::K_WRAPCFG)
          r = qcm ? qiorw_pkg::ADR_QUAD_CLKS : qiorw_pkg::WRAP_DUMMY_CLKS;
      qiorw_pkg::PH_MODE:
        if (has_mode(k) || k == qiorw_pkg::K_PARAM)
          r = qiorw_pkg::BYTE_QUAD_CLKS;
        else if (k == qiorw_pkg::K_WRAPCFG)
          r = qcm ? qiorw_pkg::BYTE_QUAD_CLKS : qiorw_pkg::BYTE_SINGLE_CLKS;
      qiorw_pkg::PH_DUM:
        case (k)
          // mode byte is counted inside the configured dummies
          qiorw_pkg::K_FAST: r = qcm ? qpi_dummy(ds) - qiorw_pkg::BYTE_QUAD_CLKS : qiorw_pkg::DUM_FAST_CLKS;
          qiorw_pkg::K_WORD: r = qiorw_pkg::DUM_WORD_CLKS;
          qiorw_pkg::K_BURST: r = qpi_dummy(ds);
          default: r = 5'd0;
        endcase
      qiorw_pkg::PH_DATA:
        r = {4'h0, is_read(k)};
      default: r = 5'd0;
    endcase
    return r;
  endfunction

  function automatic qiorw_pkg::qiorw_phase_t nph(input qiorw_pkg::qiorw_kind_t k, input logic qcm,
                                                  input logic [1:0] ds, input logic skip,
                                                  input qiorw_pkg::qiorw_phase_t cur);
    qiorw_pkg::qiorw_phase_t r;
    r = qiorw_pkg::PH_END;
    for (int i = int'(qiorw_pkg::PH_DATA); i > int'(cur); i--)
      if (plen(k, qcm, ds, skip, qiorw_pkg::qiorw_phase_t'(i)) != 5'd0)
        r = qiorw_pkg::qiorw_phase_t'(i);
    return r;
  endfunction

  function automatic logic is_quad(input qiorw_pkg::qiorw_kind_t k, input logic qcm,
                                   input qiorw_pkg::qiorw_phase_t ph);
    logic r;
    r = 1'b0;
    case (ph)
      qiorw_pkg::PH_OPC: r = qcm && k != qiorw_pkg::K_EXIT;
      qiorw_pkg::PH_ADR, qiorw_pkg::PH_MODE: r = k != qiorw_pkg::K_WRAPCFG || qcm;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] load_sh(input qiorw_pkg::qiorw_kind_t k, input logic [23:0] a, input logic c,
                                          input qiorw_pkg::qiorw_phase_t ph);
    logic [7:0] op;
    logic [31:0] r;
    op = qiorw_pkg::EXIT_BYTE;
    r = 32'h0000_0000;
    case (k)
      qiorw_pkg::K_FAST: op = qiorw_pkg::OPC_FAST;
      qiorw_pkg::K_WORD: op = qiorw_pkg::OPC_WORD;
      qiorw_pkg::K_OCTAL: op = qiorw_pkg::OPC_OCTAL;
      qiorw_pkg::K_WRAPCFG: op = qiorw_pkg::OPC_WRAPCFG;
      qiorw_pkg::K_PARAM: op = qiorw_pkg::OPC_PARAM;
      qiorw_pkg::K_BURST: op = qiorw_pkg::OPC_BURST;
      default: op = qiorw_pkg::EXIT_BYTE;
    endcase
    case (ph)
      qiorw_pkg::PH_OPC: r = {op, 24'h00_0000};
      qiorw_pkg::PH_ADR: r = (k == qiorw_pkg::K_WRAPCFG) ? 32'h0000_0000 : {a, 8'h00};
      qiorw_pkg::PH_MODE:
        // wrap bits and read parameters travel in the low address byte
        if (k == qiorw_pkg::K_WRAPCFG || k == qiorw_pkg::K_PARAM)
          r = {a[7:0], 24'h00_0000};
        else
          r = {c ? qiorw_pkg::MODE_CONT : qiorw_pkg::MODE_NORMAL, 24'h00_0000};
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  logic busy;
  assign busy = s.ph != qiorw_pkg::PH_IDLE || s.start;

  always_comb
  begin
    qiorw_pkg::qiorw_phase_t p;
    logic ld;
    logic drv;
    logic q;
    logic skip_now;
    logic refuse;
    logic [31:0] r;
    p = qiorw_pkg::PH_IDLE;
    ld = 1'b0;
    drv = 1'b0;
    q = 1'b0;
    r = 32'h0000_0000;
    n = s;
    n.s1 = io_in;
    n.s2 = s.s1;
    skip_now = s.cont_active && s.kind == s.cont_kind && has_mode(s.kind);
    refuse = (has_mode(s.kind) && !s.qe)
           || (s.kind == qiorw_pkg::K_WORD && s.addr[0])
           || (s.kind == qiorw_pkg::K_OCTAL && s.addr[3:0] != 4'h0)
           || (s.qcm && s.kind inside {qiorw_pkg::K_WORD, qiorw_pkg::K_OCTAL, qiorw_pkg::K_WRAPCFG})
           || (!s.qcm && s.kind inside {qiorw_pkg::K_PARAM, qiorw_pkg::K_BURST})
           || (is_read(s.kind) && s.len == 16'h0000)
           || s.kind == qiorw_pkg::K_RSVD
           // a different command while continuous mode holds needs the exit sequence first
           || (s.cont_active && s.kind != s.cont_kind && s.kind != qiorw_pkg::K_EXIT);
    if (s.rel)
    begin
      n.io_oe = 4'h0;
      n.rel = 1'b0;
    end
    // bus data phase of a write
    if (s.a_sel && s.a_wr)
    begin
      case (s.a_addr)
        qiorw_pkg::OFS_CTRL:
          if (!busy)
          begin
            n.kind = qiorw_pkg::qiorw_kind_t'(hwdata[qiorw_pkg::CTRL_KIND_LSB +: 3]);
            n.cont_req = hwdata[qiorw_pkg::CTRL_CONT_BIT];
            n.start = hwdata[qiorw_pkg::CTRL_START_BIT];
          end
        qiorw_pkg::OFS_ADDR: if (!busy) n.addr = hwdata[23:0];
        qiorw_pkg::OFS_CFG:
          if (!busy)
          begin
            n.qe = hwdata[qiorw_pkg::CFG_QE_BIT];
            n.qcm = hwdata[qiorw_pkg::CFG_QCM_BIT];
            n.dsel = hwdata[qiorw_pkg::CFG_DSEL_LSB +: 2];
          end
        qiorw_pkg::OFS_LEN: if (!busy) n.len = hwdata[15:0];
        qiorw_pkg::OFS_STATUS: if (hwdata[qiorw_pkg::ST_REFUSED_BIT]) n.refused = 1'b0;
        default: ;
      endcase
    end
    // bus address phase; read data are registered here
    n.a_sel = hsel && htrans[1] && hready;
    n.a_wr = hwrite;
    n.a_addr = haddr[7:0];
    if (hsel && htrans[1] && hready && !hwrite)
    begin
      case (haddr[7:0])
        qiorw_pkg::OFS_CTRL:
        begin
          r[qiorw_pkg::CTRL_KIND_LSB +: 3] = s.kind;
          r[qiorw_pkg::CTRL_CONT_BIT] = s.cont_req;
        end
        qiorw_pkg::OFS_ADDR: r[23:0] = s.addr;
        qiorw_pkg::OFS_CFG:
        begin
          r[qiorw_pkg::CFG_QE_BIT] = s.qe;
          r[qiorw_pkg::CFG_QCM_BIT] = s.qcm;
          r[qiorw_pkg::CFG_DSEL_LSB +: 2] = s.dsel;
        end
        qiorw_pkg::OFS_LEN: r[15:0] = s.len;
        qiorw_pkg::OFS_STATUS:
        begin
          r[qiorw_pkg::ST_BUSY_BIT] = busy;
          r[qiorw_pkg::ST_VALID_BIT] = s.valid;
          r[qiorw_pkg::ST_REFUSED_BIT] = s.refused;
          r[qiorw_pkg::ST_CONT_BIT] = s.cont_active;
        end
        qiorw_pkg::OFS_DATA:
        begin
          r[7:0] = s.data;
          n.valid = 1'b0;
        end
        default: r = 32'h0000_0000;
      endcase
      n.hrdata = r;
    end
    // serial sequencer; hardware sets below win over software clears above
    case (s.ph)
      qiorw_pkg::PH_IDLE:
        if (s.start)
        begin
          n.start = 1'b0;
          if (refuse)
            n.refused = 1'b1;
          else
          begin
            n.cs_n = 1'b0;
            n.sclk = 1'b0;
            n.div = 8'h00;
            n.cnt = s.len;
            n.skip = skip_now;
            p = nph(s.kind, s.qcm, s.dsel, skip_now, qiorw_pkg::PH_IDLE);
            ld = 1'b1;
          end
        end
      qiorw_pkg::PH_END:
        if (s.div == HALF_LAST)
        begin
          n.cs_n = 1'b1;
          n.ph = qiorw_pkg::PH_IDLE;
          n.div = 8'h00;
          if (has_mode(s.kind))
          begin
            n.cont_active = s.cont_req;
            n.cont_kind = s.kind;
          end
          if (s.kind == qiorw_pkg::K_EXIT)
            n.cont_active = 1'b0;
          if (s.kind == qiorw_pkg::K_PARAM)
            n.dsel = s.addr[qiorw_pkg::PARAM_DSEL_LSB +: 2];
        end
        else
          n.div = s.div + 8'h01;
      default:
        if (s.div != HALF_LAST)
          n.div = s.div + 8'h01;
        else if (!s.sclk)
        begin
          // no buffer: the clock waits low until software has taken the previous byte
          if (!(s.ph == qiorw_pkg::PH_DATA && !s.nib && s.valid))
          begin
            n.sclk = 1'b1;
            n.div = 8'h00;
            if (s.ph != qiorw_pkg::PH_DATA && s.left == 5'd1
                && nph(s.kind, s.qcm, s.dsel, s.skip, s.ph) == qiorw_pkg::PH_DATA)
              n.rel = 1'b1;
          end
        end
        else
        begin
          n.sclk = 1'b0;
          n.div = 8'h00;
          if (s.ph == qiorw_pkg::PH_DATA)
          begin
            if (!s.nib)
            begin
              n.rx = s.s2;
              n.nib = 1'b1;
            end
            else
            begin
              n.data = {s.rx, s.s2};
              n.valid = 1'b1;
              n.nib = 1'b0;
              n.cnt = s.cnt - 16'h0001;
              if (s.cnt == 16'h0001)
              begin
                p = qiorw_pkg::PH_END;
                ld = 1'b1;
              end
            end
          end
          else if (s.left == 5'd1)
          begin
            p = nph(s.kind, s.qcm, s.dsel, s.skip, s.ph);
            ld = 1'b1;
          end
          else
          begin
            n.left = s.left - 5'd1;
            n.sh = is_quad(s.kind, s.qcm, s.ph) ? {s.sh[27:0], 4'h0} : {s.sh[30:0], 1'b0};
            drv = 1'b1;
          end
        end
    endcase
    if (ld)
    begin
      n.ph = p;
      n.left = plen(s.kind, s.qcm, s.dsel, n.skip, p);
      n.sh = load_sh(s.kind, s.addr, s.cont_req, p);
      n.nib = 1'b0;
      drv = 1'b1;
    end
    if (drv)
    begin
      q = is_quad(s.kind, s.qcm, n.ph);
      n.io_out = q ? n.sh[31:28] : {3'b000, n.sh[31]};
      if (n.ph inside {qiorw_pkg::PH_OPC, qiorw_pkg::PH_ADR, qiorw_pkg::PH_MODE})
        n.io_oe = q ? 4'hf : 4'h1;
      else
        n.io_oe = 4'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s <= '0;
      s.cs_n <= 1'b1;
    end
    else
      s <= n;
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s.hrdata;
  assign flash = '{cs_n: s.cs_n, sclk: s.sclk, io_out: s.io_out, io_oe: s.io_oe};

  // helper counters for the checks below
  logic [7:0] hi_cnt;
  logic [7:0] rise_cnt;
  logic sclk_d;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hi_cnt <= 8'h00;
      rise_cnt <= 8'h00;
      sclk_d <= 1'b0;
    end
    else
    begin
      sclk_d <= s.sclk;
      hi_cnt <= s.sclk ? hi_cnt + 8'h01 : 8'h00;
      rise_cnt <= s.cs_n ? 8'h00 : rise_cnt + {7'h00, s.sclk && !sclk_d};
    end
  end

  property p_qe_gate;
    @(posedge hclk) disable iff (!hresetn) $fell(s.cs_n) && has_mode(s.kind) |-> s.qe;
  endproperty
  a_qe_gate: assert property (p_qe_gate) else $error("quad read started without quad enable");

  property p_quad_addr;
    @(posedge hclk) disable iff (!hresetn)
      s.ph == qiorw_pkg::PH_ADR && is_read(s.kind) && $rose(s.sclk) |-> s.io_oe == 4'hf;
  endproperty
  a_quad_addr: assert property (p_quad_addr) else $error("read address not on four lines");

  property p_half_period;
    @(posedge hclk) disable iff (!hresetn) $fell(s.sclk) |-> hi_cnt == 8'(HALF_CYCLES);
  endproperty
  a_half_period: assert property (p_half_period) else $error("serial clock high time wrong");

  property p_fast_lead;
    @(posedge hclk) disable iff (!hresetn)
      $rose(s.ph == qiorw_pkg::PH_DATA) && s.kind == qiorw_pkg::K_FAST && !s.qcm && !s.skip |-> rise_cnt == 8'd20;
  endproperty
  a_fast_lead: assert property (p_fast_lead) else $error("fast read lead-in clock count wrong");

  property p_cont_skip;
    @(posedge hclk) disable iff (!hresetn) $fell(s.cs_n) && s.skip |-> s.ph == qiorw_pkg::PH_ADR;
  endproperty
  a_cont_skip: assert property (p_cont_skip) else $error("continuous read did not skip the opcode");

  property p_word_read;
    @(posedge hclk) disable iff (!hresetn)
      $rose(s.ph == qiorw_pkg::PH_DATA) && s.kind == qiorw_pkg::K_WORD && !s.skip
      |-> rise_cnt == 8'd18 && !s.addr[0];
  endproperty
  a_word_read: assert property (p_word_read) else $error("word read lead-in or alignment wrong");

  property p_octal;
    @(posedge hclk) disable iff (!hresetn)
      $fell(s.cs_n) && s.kind == qiorw_pkg::K_OCTAL |-> s.addr[3:0] == 4'h0 && s.qe;
  endproperty
  a_octal: assert property (p_octal) else $error("octal read misaligned or without quad enable");

  property p_wrap_frame;
    @(posedge hclk) disable iff (!hresetn)
      $rose(s.cs_n) && s.kind == qiorw_pkg::K_WRAPCFG && !s.qcm |-> $past(rise_cnt) == 8'd40;
  endproperty
  a_wrap_frame: assert property (p_wrap_frame) else $error("wrap configuration frame length wrong");

  property p_release;
    @(posedge hclk) disable iff (!hresetn) $rose(s.ph == qiorw_pkg::PH_DATA) |-> $past(s.io_oe) == 4'h0;
  endproperty
  a_release: assert property (p_release) else $error("lines still driven at first data edge");

  property p_exit;
    @(posedge hclk) disable iff (!hresetn)
      s.kind == qiorw_pkg::K_EXIT && s.ph == qiorw_pkg::PH_OPC |-> s.io_out[0] && s.io_oe == 4'h1;
  endproperty
  a_exit: assert property (p_exit) else $error("exit sequence not all ones on line zero");

endmodule // qiorw_host

// ===== dv/qiorw_flash_model.sv
// behavioural serial flash answering quad reads, continuous mode and wrap setup
`timescale 1ns/10ps
module qiorw_flash_model (
  // link from the host
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] io,
  // link width the bench has put the device in
  input wire logic quad_command_mode,
  // device drive of the shared lines
  output logic [3:0] dev_out,
  output logic dev_en
);
  logic cont = 1'b0;
  logic [7:0] cont_opc = 8'h00;
  logic wdis = 1'b1;
  logic [1:0] wlen = 2'b00;
  // read parameters are not cleared when the link width changes
  logic [1:0] pdum = 2'b00;
  logic [1:0] plen = 2'b00;
  // no program or erase path here, so the array never reports busy
  logic wip = 1'b0;

  task automatic frame();
    logic [7:0] opc;
    logic [7:0] b;
    logic [23:0] a;
    logic [23:0] m;
    int d;
    opc = cont_opc;
    if (!cont)
      repeat (quad_command_mode ? 2 : 8) @(posedge sclk) opc = quad_command_mode ? {opc[3:0], io} : {opc[6:0], io[0]};
    if (opc == 8'h77)
    begin
      repeat (24) @(posedge sclk);
      repeat (8) @(posedge sclk) b = {b[6:0], io[0]};
      wdis = b[4];
      wlen = b[6:5];
    end
    else if (opc == 8'hc0)
    begin
      repeat (2) @(posedge sclk) b = {b[3:0], io};
      pdum = b[5:4];
      plen = b[1:0];
    end
    else
    begin
      repeat (6) @(posedge sclk) a = {a[19:0], io};
      if (opc != 8'h0c)
      begin
        repeat (2) @(posedge sclk) b = {b[3:0], io};
        cont = (b[5:4] == 2'b10);
      end
      cont_opc = opc;
      d = (pdum == 2'b00) ? 10 : 2 * pdum + 2;
      if (!quad_command_mode)
        d = opc == 8'heb ? 4 : opc == 8'he7 ? 2 : 0;
      else if (opc == 8'heb)
        d = d - 2;
      repeat (d) @(posedge sclk);
      if (opc == 8'h0c)
        m = (24'd8 << plen) - 24'd1;
      else
        m = (wdis || quad_command_mode || opc == 8'he3) ? 24'hffffff : (24'd8 << wlen) - 24'd1;
      if (wip)
        @(posedge cs_n);
      forever
      begin
        b = a[7:0] ^ a[15:8] ^ 8'h3c;
        @(negedge sclk) dev_out = b[7:4];
        dev_en = 1'b1;
        @(negedge sclk) dev_out = b[3:0];
        a = (a & ~m) | ((a + 24'd1) & m);
      end
    end
  endtask

  // select rising drops whatever was half received
  initial
  begin
    dev_en = 1'b0;
    dev_out = 4'h0;
    forever
    begin
      wait (cs_n === 1'b0);
      fork
        frame();
        @(posedge cs_n);
      join_any
      disable fork;
      dev_en = 1'b0;
      wait (cs_n === 1'b1);
    end
  end
endmodule // qiorw_flash_model

// ===== dv/testbench.sv
// self-checking bench of the quad read host engine against the flash model
`timescale 1ns/10ps
module testbench;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, dev_en, qpi_mode;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] io_in, dev_out;
  logic [23:0] a;
  qiorw_pkg::qiorw_pins_t flash;
  int mismatches, checks, cycles;
  logic [31:0] exp_q[$], obs_q[$];
  string name_q[$];

  // released lines float up through the board pull-ups
  assign io_in = (flash.io_oe & flash.io_out) | (~flash.io_oe & (dev_en ? dev_out : 4'hf));

  qiorw_host #(.HALF_CYCLES(4)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .io_in(io_in), .flash(flash));
  qiorw_flash_model i_flash (.cs_n(flash.cs_n), .sclk(flash.sclk), .io(io_in), .dev_out(dev_out),
    .quad_command_mode(qpi_mode), .dev_en(dev_en));

  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 50000)
    begin
      mismatches++;
      print_verdict();
    end
    else if (obs_q.size() > 0)
    begin
      checks++;
      if (obs_q[0] !== exp_q[0])
      begin
        mismatches++;
        $display("wrong value %s expected %h seen %h", name_q[0], exp_q[0], obs_q[0]);
      end
      void'(obs_q.pop_front());
      void'(exp_q.pop_front());
      void'(name_q.pop_front());
    end
  end

  task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0, ad};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    name_q.push_back("hresp");
    exp_q.push_back(32'h0);
    obs_q.push_back({31'h0, hresp});
  endtask

  task automatic chk(input string nm, input logic [7:0] ad, input logic [31:0] msk, input logic [31:0] e);
    bus(1'b0, ad, 32'h0);
    name_q.push_back(nm);
    exp_q.push_back(e);
    obs_q.push_back(r & msk);
  endtask

  task automatic poll(input int b, input logic v);
    do bus(1'b0, qiorw_pkg::OFS_STATUS, 32'h0); while (r[b] !== v);
  endtask

  task automatic start(input logic [2:0] k, input logic c, input logic [23:0] ad, input int n);
    bus(1'b1, qiorw_pkg::OFS_ADDR, {8'h0, ad});
    bus(1'b1, qiorw_pkg::OFS_LEN, {16'h0, n[15:0]});
    bus(1'b1, qiorw_pkg::OFS_CTRL, {23'h0, 1'b1, 3'h0, c, 1'b0, k});
    repeat (3) @(posedge hclk);
  endtask

  task automatic stream(input logic [2:0] k, input logic c, input logic [23:0] ad, input int n, input logic [23:0] m);
    start(k, c, ad, n);
    repeat (n)
    begin
      poll(qiorw_pkg::ST_VALID_BIT, 1'b1);
      chk("data", qiorw_pkg::OFS_DATA, 32'hff, {24'h0, ad[7:0] ^ ad[15:8] ^ 8'h3c});
      ad = (ad & ~m) | ((ad + 24'd1) & m);
    end
    poll(qiorw_pkg::ST_BUSY_BIT, 1'b0);
  endtask

  task automatic refuse(input logic [2:0] k, input logic [23:0] ad);
    start(k, 1'b0, ad, 4);
    chk("refused", qiorw_pkg::OFS_STATUS, 32'h5, 32'h4);
    bus(1'b1, qiorw_pkg::OFS_STATUS, 32'h4);
  endtask

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'b00;
    hsize = 3'b010;
    qpi_mode = 1'b0;
    mismatches = 0;
    checks = 0;
    cycles = 0;
    r = $urandom(32'ha4df2860);
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b1, qiorw_pkg::OFS_CFG, 32'h0);
    refuse(3'd0, 24'h0);
    refuse(3'd1, 24'h0);
    bus(1'b1, qiorw_pkg::OFS_CFG, 32'h1);
    refuse(3'd1, 24'h000101);
    refuse(3'd2, 24'h000108);
    refuse(3'd4, 24'h0);
    stream(3'd0, 1'b0, 24'hfffffe, 3, 24'hffffff);
    a = $urandom;
    stream(3'd0, 1'b0, a, 2, 24'hffffff);
    stream(3'd2, 1'b1, 24'h004560, 2, 24'hffffff);
    chk("cont", qiorw_pkg::OFS_STATUS, 32'h8, 32'h8);
    stream(3'd2, 1'b1, 24'h0089a0, 2, 24'hffffff);
    stream(3'd2, 1'b0, 24'h000010, 1, 24'hffffff);
    stream(3'd0, 1'b0, 24'h000123, 2, 24'hffffff);
    stream(3'd1, 1'b1, 24'h000222, 2, 24'hffffff);
    stream(3'd6, 1'b0, 24'h0, 0, 24'hffffff);
    chk("cont", qiorw_pkg::OFS_STATUS, 32'h8, 32'h0);
    stream(3'd1, 1'b0, 24'h000340, 2, 24'hffffff);
    for (int w = 0; w < 4; w++)
    begin
      stream(3'd3, 1'b0, {17'h0, w[1:0], 5'h0}, 0, 24'hffffff);
      stream(3'd1, 1'b0, 24'h000100 | ((24'd8 << w) - 24'd2), 4, (24'd8 << w) - 24'd1);
    end
    stream(3'd0, 1'b0, 24'h00053e, 3, 24'h00003f);
    bus(1'b1, qiorw_pkg::OFS_CFG, 32'h3);
    qpi_mode <= 1'b1;
    stream(3'd4, 1'b0, 24'h000013, 0, 24'hffffff);
    chk("dsel", qiorw_pkg::OFS_CFG, 32'h30, 32'h10);
    stream(3'd5, 1'b0, 24'h00077e, 3, 24'h00003f);
    stream(3'd0, 1'b0, 24'h00053e, 3, 24'hffffff);
    bus(1'b1, qiorw_pkg::OFS_CFG, 32'h1);
    qpi_mode <= 1'b0;
    stream(3'd3, 1'b0, 24'h000010, 0, 24'hffffff);
    stream(3'd1, 1'b0, 24'h00012e, 3, 24'hffffff);
    repeat (3) @(posedge hclk);
    print_verdict();
  end
endmodule // testbench
